// ==== ics_consts.svh ====
// ics_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the host, the slave and the testbench
`ifndef ICS_CONSTS_SVH
`define ICS_CONSTS_SVH

// slave address and byte map
`define ICS_ADDR_FIXED 5'h1A
`define ICS_RO_BYTE 3'h0
`define ICS_NUM_BYTES 7'h08
// manufacturer field value is arbitrary
`define ICS_MANF_BITS 7'h00
`define ICS_RST_BYTES 64'h89F0FF2700272000
`define ICS_BAD_RDATA 8'hFF
`define ICS_SYNC_RST 5'h03

// timing
`define ICS_CLK_NS 4
`define ICS_SCL_PERIOD_NS 2500
`define ICS_QTR_CYC ((`ICS_SCL_PERIOD_NS / 4 + `ICS_CLK_NS - 1) / `ICS_CLK_NS)

// controller register offsets
`define ICS_OFS_CTRL 8'h00
`define ICS_OFS_TGT 8'h04
`define ICS_OFS_WDATA 8'h08
`define ICS_OFS_RDATA 8'h0C
`define ICS_OFS_STAT 8'h10
`define ICS_OFS_IRQ_ST 8'h14
`define ICS_OFS_IRQ_CLR 8'h18
`define ICS_OFS_IRQ_EN 8'h1C

// controller fields
`define ICS_CTRL_GO_BIT 2
`define ICS_TGT_SEL_LSB 8
`define ICS_IRQ_DONE_BIT 0
`define ICS_IRQ_NACK_BIT 1

`endif

// ==== ics_pkg.sv ====
// ics_pkg.sv: state and operation types of the configuration link
// assumes: nothing beyond the compiler
package ics_pkg;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RX = 3'h1,
    D_ACK = 3'h3,
    D_TX = 3'h2,
    D_MACK = 3'h6
  } ics_dev_state_t;

  typedef enum logic [1:0] {
    P_ADDR = 2'h0,
    P_CMD = 2'h1,
    P_DATA = 2'h3
  } ics_phase_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_TX = 3'h3,
    H_RX = 3'h2,
    H_STOP = 3'h6
  } ics_host_state_t;

  typedef enum logic [1:0] {
    OP_BYTE_WR = 2'h0,
    OP_BYTE_RD = 2'h1,
    OP_WORD_WR = 2'h2,
    OP_WORD_RD = 2'h3
  } ics_op_t;

endpackage : ics_pkg

// ==== ics_bus_if.sv ====
// ics_bus_if.sv: two-wire link between controller and configuration slave
// assumes: pull-ups on both lines; each end drives low only
`timescale 1ns/1ns
`default_nettype none

interface ics_bus_if;
  logic m_scl_o;
  logic m_scl_oe_b;
  logic m_sda_o;
  logic m_sda_oe_b;
  logic s_sda_o;
  logic s_sda_oe_b;
  logic scl;
  logic sda;

  // wired-and of the open-drain drivers with pull-up
  assign scl = m_scl_oe_b | m_scl_o;
  assign sda = (m_sda_oe_b | m_sda_o) & (s_sda_oe_b | s_sda_o);

  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe_b);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe_b,
                output m_sda_o, output m_sda_oe_b);
endinterface : ics_bus_if

`default_nettype wire

// ==== ics_host.sv ====
// ics_host.sv: link controller, ordered over apb, makes the serial clock
// assumes: apb on SYS_CLK_I; slave at the far end of LINK
`timescale 1ns/1ns
`default_nettype none
`include "ics_consts.svh"

module ics_host (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  ics_bus_if.host LINK
);
  import ics_pkg::*;

  localparam logic [7:0] QTR_LAST = 8'(`ICS_QTR_CYC - 1);

  ics_host_state_t state_reg, state_next;
  ics_op_t op_reg;
  logic [9:0] tgt_reg;
  logic [15:0] wdata_reg, rdata_reg, rdata_next;
  logic [1:0] irq_st_reg, irq_en_reg;
  logic nack_reg;
  logic [7:0] div_reg;
  logic [1:0] qtr_reg;
  logic [2:0] item_reg, item_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic [1:0] sda_sync_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic ev_done, ev_nack;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire logic apb_setup = PSEL_I & ~PENABLE_I;
  wire logic sel_ctrl = PADDR_I == `ICS_OFS_CTRL;
  wire logic sel_tgt = PADDR_I == `ICS_OFS_TGT;
  wire logic sel_wdata = PADDR_I == `ICS_OFS_WDATA;
  wire logic sel_rdata = PADDR_I == `ICS_OFS_RDATA;
  wire logic sel_stat = PADDR_I == `ICS_OFS_STAT;
  wire logic sel_ist = PADDR_I == `ICS_OFS_IRQ_ST;
  wire logic sel_iclr = PADDR_I == `ICS_OFS_IRQ_CLR;
  wire logic sel_ien = PADDR_I == `ICS_OFS_IRQ_EN;
  wire logic hit = sel_ctrl | sel_tgt | sel_wdata | sel_rdata | sel_stat |
                   sel_ist | sel_iclr | sel_ien;
  wire logic busy = state_reg != H_IDLE;
  wire logic go = apb_wr & sel_ctrl & PWDATA_I[`ICS_CTRL_GO_BIT] & ~busy;
  wire logic [1:0] irq_clr = (apb_wr & sel_iclr) ? PWDATA_I[1:0] : 2'h0;
  wire logic [31:0] rd_mux =
    sel_ctrl ? {30'h0, op_reg} :
    sel_tgt ? {22'h0, tgt_reg} :
    sel_wdata ? {16'h0, wdata_reg} :
    sel_rdata ? {16'h0, rdata_reg} :
    sel_stat ? {30'h0, nack_reg, busy} :
    sel_ist ? {30'h0, irq_st_reg} :
    sel_ien ? {30'h0, irq_en_reg} : 32'h0;

  assign PRDATA_O = prdata_reg;
  assign PSLVERR_O = pslverr_reg;
  assign PREADY_O = 1'b1;
  assign IRQ_O = |(irq_st_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////
  // sequence of one transfer
  wire logic is_rd = op_reg == OP_BYTE_RD || op_reg == OP_WORD_RD;
  wire logic is_wd = op_reg == OP_WORD_WR || op_reg == OP_WORD_RD;
  wire logic [6:0] dev_addr = {`ICS_ADDR_FIXED, tgt_reg[9:8]};

  function automatic ics_host_state_t kind_of(input logic [2:0] it,
                                              input logic rd, input logic wd);
    kind_of = H_STOP;
    if (it == 3'h0) kind_of = H_START;
    else if (it < 3'h3) kind_of = H_TX;
    else if (!rd) kind_of = (it == 3'h3 || (it == 3'h4 && wd)) ? H_TX : H_STOP;
    else if (it == 3'h3) kind_of = H_START;
    else if (it == 3'h4) kind_of = H_TX;
    else if (it == 3'h5 || (it == 3'h6 && wd)) kind_of = H_RX;
  endfunction : kind_of

  wire logic [2:0] item_inc = item_reg + 3'h1;
  wire ics_host_state_t kind_nx = kind_of(item_inc, is_rd, is_wd);
  wire logic [7:0] tx_nx =
    (item_inc == 3'h1) ? {dev_addr, 1'b0} :
    (item_inc == 3'h2) ? tgt_reg[7:0] :
    (item_inc == 3'h3) ? wdata_reg[7:0] :
    (item_inc == 3'h4 && is_rd) ? {dev_addr, 1'b1} :
    (item_inc == 3'h4) ? wdata_reg[15:8] : `ICS_BAD_RDATA;
  // acknowledge the first byte of a word read only
  wire logic rx_ack = (item_reg == 3'h5) && is_wd;
  wire logic last_bit = bit_reg == 4'h8;
  wire logic tick = busy && div_reg == QTR_LAST;
  wire logic sda_s = sda_sync_reg[1];
  wire logic v1 =
    (state_reg == H_START) ? 1'b1 :
    (state_reg == H_STOP) ? 1'b0 :
    (state_reg == H_TX) ? (last_bit | sh_reg[7]) :
    (last_bit ? ~rx_ack : 1'b1);

  always_comb begin
    state_next = state_reg;
    item_next = item_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    scl_next = scl_reg;
    sda_next = sda_reg;
    rdata_next = rdata_reg;
    ev_done = 1'b0;
    ev_nack = 1'b0;
    if (go) begin
      state_next = H_START;
      item_next = 3'h0;
      scl_next = 1'b0;
    end else if (tick) begin
      unique case (qtr_reg)
        2'h0: sda_next = v1;
        2'h1: scl_next = 1'b1;
        2'h2: if (state_reg == H_START || state_reg == H_STOP) sda_next = ~v1;
        2'h3: begin
          scl_next = 1'b0;
          if (state_reg == H_STOP) begin
            state_next = H_IDLE;
            scl_next = 1'b1;
            ev_done = 1'b1;
          end else if ((state_reg == H_TX || state_reg == H_RX) && !last_bit) begin
            sh_next = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (state_reg == H_TX && sda_s) begin
            state_next = H_STOP;
            item_next = 3'h7;
            ev_nack = 1'b1;
          end else begin
            if (state_reg == H_RX && item_reg == 3'h5) rdata_next[7:0] = sh_reg;
            if (state_reg == H_RX && item_reg == 3'h6) rdata_next[15:8] = sh_reg;
            state_next = kind_nx;
            item_next = item_inc;
            sh_next = tx_nx;
            bit_next = 4'h0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      state_reg <= H_IDLE;
      item_reg <= 3'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      div_reg <= 8'h00;
      qtr_reg <= 2'h0;
      sda_sync_reg <= 2'h3;
    end else if (CE_I) begin
      state_reg <= state_next;
      item_reg <= item_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      div_reg <= (go || tick) ? 8'h00 : div_reg + 8'h01;
      qtr_reg <= go ? 2'h0 : (tick ? qtr_reg + 2'h1 : qtr_reg);
      sda_sync_reg <= {sda_sync_reg[0], LINK.sda};
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      op_reg <= OP_BYTE_WR;
      tgt_reg <= 10'h000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      nack_reg <= 1'b0;
      irq_st_reg <= 2'h0;
      irq_en_reg <= 2'h0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (CE_I) begin
      if (go) op_reg <= ics_op_t'(PWDATA_I[1:0]);
      if (apb_wr && sel_tgt && !busy) tgt_reg <= PWDATA_I[9:0];
      if (apb_wr && sel_wdata && !busy) wdata_reg <= PWDATA_I[15:0];
      if (apb_wr && sel_ien) irq_en_reg <= PWDATA_I[1:0];
      rdata_reg <= rdata_next;
      nack_reg <= go ? 1'b0 : (nack_reg | ev_nack);
      irq_st_reg <= (irq_st_reg & ~irq_clr) | {ev_nack, ev_done};
      if (apb_setup) prdata_reg <= rd_mux;
      if (apb_setup) pslverr_reg <= ~hit;
    end
  end

  assign LINK.m_scl_o = 1'b0;
  assign LINK.m_scl_oe_b = scl_reg;
  assign LINK.m_sda_o = 1'b0;
  assign LINK.m_sda_oe_b = sda_reg;

endmodule : ics_host

`default_nettype wire

// ==== ics_dev.sv ====
// ics_dev.sv: two-wire configuration slave holding eight bytes
// assumes: serial clock made by the master; pins sampled on SYS_CLK_I
`timescale 1ns/1ns
`default_nettype none
`include "ics_consts.svh"

// Operation
// - slave only, seven-bit addresses only
// - address is 11010 then two select pins
// - answer one of four addresses, ignore others
// - eighth address bit zero writes, one reads
// - serial clock up to 400 kHz
// - command top bit one requests byte access
// - low seven command bits give byte offset
// - word reaches offset and next, seven alone
// - byte write acknowledged address, command, data
// - byte read: command, repeated start, one byte
// - status output high while pll locked
// - word read returns two bytes, ack then nack
// - byte zero top bit is lock flag
module ics_dev (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic ADDR_SELECT_HI_PIN_I,
  input wire logic ADDR_SELECT_LO_PIN_I,
  input wire logic PLL_LOCK_I,
  output logic STATUS_O,
  output logic [63:0] CFG_O,
  ics_bus_if.dev LINK
);
  import ics_pkg::*;

  localparam logic [63:0] RST_BYTES = `ICS_RST_BYTES;

  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [4:0] pins_w;
  logic scl_prev_reg;
  logic sda_prev_reg;
  ics_dev_state_t state_reg, state_next;
  ics_phase_t phase_reg, phase_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic got_reg, got_next;
  logic rw_reg, rw_next;
  logic cmd_ok_reg, cmd_ok_next;
  logic [6:0] ptr_reg, ptr_next;
  logic drv_reg, drv_next;
  logic mack_reg, mack_next;
  logic [7:0] cfg_reg [7:1];
  logic [7:0] byte_w [8];

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pins_w = {PLL_LOCK_I, ADDR_SELECT_HI_PIN_I, ADDR_SELECT_LO_PIN_I,
                   LINK.sda, LINK.scl};

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      meta_reg <= `ICS_SYNC_RST;
      sync_reg <= `ICS_SYNC_RST;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (CE_I) begin
      meta_reg <= pins_w;
      sync_reg <= meta_reg;
      scl_prev_reg <= sync_reg[0];
      sda_prev_reg <= sync_reg[1];
    end
  end

  wire logic scl_s = sync_reg[0];
  wire logic sda_s = sync_reg[1];
  wire logic [1:0] addr_sel = sync_reg[3:2];
  wire logic lock_s = sync_reg[4];

  ////////////////////////////////////////////////////////////////////////
  // line events
  wire logic scl_rise = scl_s & ~scl_prev_reg;
  wire logic scl_fall = ~scl_s & scl_prev_reg;
  wire logic start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire logic stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  wire logic [7:0] rx_byte = {shift_reg[6:0], sda_s};

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire logic [6:0] my_addr = {`ICS_ADDR_FIXED, addr_sel};
  wire logic addr_hit = shift_reg[7:1] == my_addr;
  wire logic ptr_ok = cmd_ok_reg && (ptr_reg < `ICS_NUM_BYTES);
  wire logic [6:0] ptr_inc = ptr_ok ? ptr_reg + 7'h01 : ptr_reg;
  wire logic [7:0] rd_byte = ptr_ok ? byte_w[ptr_reg[2:0]] : `ICS_BAD_RDATA;
  wire logic byte_end = got_reg & scl_fall;
  wire logic wr_en = (state_reg == D_RX) && (phase_reg == P_DATA) && byte_end &&
                     ptr_ok && (ptr_reg[2:0] != `ICS_RO_BYTE);

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    got_next = got_reg;
    rw_next = rw_reg;
    cmd_ok_next = cmd_ok_reg;
    ptr_next = ptr_reg;
    drv_next = drv_reg;
    mack_next = mack_reg;
    if (start_det) begin
      state_next = D_RX;
      phase_next = P_ADDR;
      cnt_next = 4'h0;
      got_next = 1'b0;
      drv_next = 1'b0;
    end else if (stop_det) begin
      state_next = D_IDLE;
      drv_next = 1'b0;
    end else begin
      unique case (state_reg)
        D_IDLE: begin
          drv_next = 1'b0;
        end
        D_RX: begin
          if (scl_rise && !got_reg) begin
            shift_next = rx_byte;
            cnt_next = cnt_reg + 4'h1;
            got_next = cnt_reg == 4'h7;
          end else if (byte_end) begin
            got_next = 1'b0;
            cnt_next = 4'h0;
            state_next = D_ACK;
            drv_next = 1'b1;
            if (phase_reg == P_ADDR) begin
              rw_next = shift_reg[0];
              if (!addr_hit) begin
                state_next = D_IDLE;
                drv_next = 1'b0;
              end
            end else if (phase_reg == P_CMD) begin
              cmd_ok_next = shift_reg[7];
              ptr_next = shift_reg[6:0];
            end else begin
              ptr_next = ptr_inc;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            drv_next = 1'b0;
            cnt_next = 4'h0;
            if (rw_reg && phase_reg == P_ADDR) begin
              state_next = D_TX;
              shift_next = rd_byte;
              drv_next = ~rd_byte[7];
            end else begin
              state_next = D_RX;
              phase_next = (phase_reg == P_ADDR) ? P_CMD : P_DATA;
            end
          end
        end
        D_TX: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            drv_next = 1'b0;
            state_next = D_MACK;
            ptr_next = ptr_inc;
          end else if (scl_fall) begin
            shift_next = {shift_reg[6:0], 1'b0};
            drv_next = ~shift_reg[6];
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;
          end else if (scl_fall && mack_reg) begin
            state_next = D_TX;
            cnt_next = 4'h0;
            shift_next = rd_byte;
            drv_next = ~rd_byte[7];
          end else if (scl_fall) begin
            state_next = D_IDLE;
          end
        end
        default: begin
          state_next = D_IDLE;
          drv_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      state_reg <= D_IDLE;
      phase_reg <= P_ADDR;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      got_reg <= 1'b0;
      rw_reg <= 1'b0;
      cmd_ok_reg <= 1'b0;
      ptr_reg <= 7'h00;
      drv_reg <= 1'b0;
      mack_reg <= 1'b0;
    end else if (CE_I) begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      got_reg <= got_next;
      rw_reg <= rw_next;
      cmd_ok_reg <= cmd_ok_next;
      ptr_reg <= ptr_next;
      drv_reg <= drv_next;
      mack_reg <= mack_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration bytes
  assign byte_w[0] = {lock_s, `ICS_MANF_BITS};
  assign CFG_O[7:0] = byte_w[0];

  for (genvar gi = 1; gi < 8; gi++) begin : g_byte
    always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
        cfg_reg[gi] <= RST_BYTES[gi*8 +: 8];
      end else if (CE_I && wr_en && ptr_reg[2:0] == 3'(gi)) begin
        cfg_reg[gi] <= shift_reg;
      end
    end
    assign byte_w[gi] = cfg_reg[gi];
    assign CFG_O[gi*8 +: 8] = cfg_reg[gi];
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign STATUS_O = lock_s;
  assign LINK.s_sda_o = 1'b0;
  assign LINK.s_sda_oe_b = ~drv_reg;

endmodule : ics_dev

`default_nettype wire

// ==== ics_link_asserts.sv ====
// ics_link_asserts.sv: wire-level checks of the two-wire configuration link
// assumes: one clock domain; lines sampled on SYS_CLK_I as both ends do
`timescale 1ns/1ns
`default_nettype none

module ics_link_asserts (
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  input wire logic ADDR_SELECT_HI_PIN_I,
  input wire logic ADDR_SELECT_LO_PIN_I,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe_b
);
  localparam int STOP_WAIT = 1000;
  localparam int MIN_PERIOD = 625;
  localparam int MIN_HIGH = 150;
  logic scl_q, sda_q, wr_mode, rd_mode;
  logic [3:0] bitn, byt;
  logic [7:0] sh;
  logic [9:0] per_cnt, hi_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // frame tracking
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_now = scl & scl_q & sda_q & ~sda;
  wire stop_now = scl & scl_q & ~sda_q & sda;
  wire ack_rise = scl_rise & (bitn == 4'h8);
  wire addr_hit = sh[7:1] == {5'h1A, ADDR_SELECT_HI_PIN_I, ADDR_SELECT_LO_PIN_I};
  wire frame_end = start_now | stop_now;
  wire addr_ack = ack_rise & (byt == 4'h0);
  wire [3:0] bitn_next = (frame_end | ack_rise) ? 4'h0 : bitn + {3'h0, scl_rise};
  wire [3:0] byt_next = start_now ? 4'h0 : byt + {3'h0, ack_rise & (byt != 4'hF)};
  wire wr_next = frame_end ? 1'b0 : (addr_ack ? addr_hit & ~sh[0] : wr_mode);
  wire rd_next = frame_end ? 1'b0 : (addr_ack ? addr_hit & sh[0] : rd_mode);
  wire [7:0] sh_next = scl_rise ? {sh[6:0], sda} : sh;
  wire [9:0] per_next = scl_rise ? 10'h0 : per_cnt + {9'h0, per_cnt != 10'h3FF};
  wire [9:0] hi_next = !scl ? 10'h0 : hi_cnt + {9'h0, hi_cnt != 10'h3FF};

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      {scl_q, sda_q, wr_mode, rd_mode} <= 4'hC;
      {bitn, byt, sh} <= 16'h0000;
      {per_cnt, hi_cnt} <= 20'hFFFFF;
    end else begin
      {scl_q, sda_q, wr_mode, rd_mode} <= {scl, sda, wr_next, rd_next};
      {bitn, byt, sh} <= {bitn_next, byt_next, sh_next};
      {per_cnt, hi_cnt} <= {per_next, hi_next};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_addr_ack;
    addr_ack |-> sda == ~addr_hit;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  property p_wr_ack;
    ack_rise && byt != 4'h0 && wr_mode |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked");
  property p_addr_quiet;
    byt == 4'h0 && (bitn < 4'h8 || (scl && scl_q)) |-> s_sda_oe_b;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove in address");
  property p_hold_high;
    scl && scl_q |-> $stable(s_sda_oe_b);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("slave moved sda on high");
  property p_rd_release;
    rd_mode && byt >= 4'h2 && bitn == 4'h0 && scl && scl_q |-> s_sda_oe_b;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("slave held master ack");
  property p_nack_stop;
    ack_rise && sda |-> ##[1:STOP_WAIT] stop_now;
  endproperty
  a_nack_stop: assert property (p_nack_stop) else $error("no stop after nack");
  property p_scl_period;
    scl_rise |-> per_cnt >= MIN_PERIOD;
  endproperty
  a_scl_period: assert property (p_scl_period) else $error("serial clock too fast");
  property p_scl_high;
    scl_fall |-> hi_cnt >= MIN_HIGH;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
endmodule : ics_link_asserts

`default_nettype wire

// ==== test_i2c_config_slave.sv ====
// test_i2c_config_slave.sv: controller and slave joined, driven over apb
// assumes: design files and ics_link_asserts compiled before this file
`timescale 1ns/1ns
`default_nettype none
`include "ics_consts.svh"

module test_i2c_config_slave;
  import ics_pkg::*;
  logic sys_clk, rst_b, ce, psel, penable, pwrite, sel_hi, sel_lo, pll_lock;
  logic pready, pslverr, irq, status, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [63:0] cfg;
  int fail_count, n_tests;

  ics_bus_if link ();
  ics_host i_ics_host (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CE_I(ce), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .LINK(link));
  ics_dev i_ics_dev (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CE_I(ce),
    .ADDR_SELECT_HI_PIN_I(sel_hi), .ADDR_SELECT_LO_PIN_I(sel_lo), .PLL_LOCK_I(pll_lock),
    .STATUS_O(status), .CFG_O(cfg), .LINK(link));
  ics_link_asserts i_ics_link_asserts (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b),
    .ADDR_SELECT_HI_PIN_I(sel_hi), .ADDR_SELECT_LO_PIN_I(sel_lo), .scl(link.scl),
    .sda(link.sda), .s_sda_oe_b(link.s_sda_oe_b));
  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic run_op(input ics_op_t op, input logic [1:0] sel, input logic [7:0] cmd,
                        input logic [15:0] wd);
    apb_xfer(1'b1, `ICS_OFS_TGT, {22'h0, sel, cmd});
    apb_xfer(1'b1, `ICS_OFS_WDATA, {16'h0, wd});
    apb_xfer(1'b1, `ICS_OFS_CTRL, {29'h0, 1'b1, op});
    do begin
      apb_xfer(1'b0, `ICS_OFS_STAT, 32'h0);
    end while (rdat[0] !== 1'b0);
  endtask : run_op

  task automatic set_lock(input logic v);
    int n;
    @(posedge sys_clk);
    pll_lock <= v;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((status !== v || cfg[7] !== v) && n < 10);
    @(negedge sys_clk);
    check_val(64'(status), 64'(v));
    check_val(64'(cfg[7]), 64'(v));
  endtask : set_lock
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    check_val(cfg, 64'h89F0FF2700272000);
    check_val(64'(status), 64'h0);
    apb_xfer(1'b0, `ICS_OFS_IRQ_EN, 32'h0);
    check_val(64'(rdat), 64'h0);
    apb_xfer(1'b0, 8'h20, 32'h0);
    check_val({31'h0, perr, rdat}, 64'h100000000);
    // a write while the clock enable is low must leave no trace
    @(posedge sys_clk);
    ce <= 1'b0;
    apb_xfer(1'b1, `ICS_OFS_IRQ_EN, 32'h3);
    @(posedge sys_clk);
    ce <= 1'b1;
    apb_xfer(1'b0, `ICS_OFS_IRQ_EN, 32'h0);
    check_val(64'(rdat), 64'h0);
    set_lock(1'b1);
  endtask : t_reset

  task automatic t_word_write;
    apb_xfer(1'b1, `ICS_OFS_IRQ_EN, 32'h1);
    run_op(OP_WORD_WR, 2'b10, 8'h80, 16'h5A3C);
    check_val(64'(rdat[1:0]), 64'h0);
    @(negedge sys_clk);
    check_val(64'(cfg[15:0]), 64'h5A80);
    check_val(64'(irq), 64'h1);
    apb_xfer(1'b1, `ICS_OFS_IRQ_CLR, 32'h3);
    @(negedge sys_clk);
    check_val(64'(irq), 64'h0);
  endtask : t_word_write

  task automatic t_byte_read;
    @(posedge sys_clk);
    sel_hi <= 1'b0;
    sel_lo <= 1'b1;
    run_op(OP_BYTE_RD, 2'b01, 8'h80, 16'h0000);
    apb_xfer(1'b0, `ICS_OFS_RDATA, 32'h0);
    check_val(64'(rdat[7:0]), 64'h80);
  endtask : t_byte_read

  task automatic t_word_read;
    apb_xfer(1'b1, `ICS_OFS_IRQ_CLR, 32'h3);
    apb_xfer(1'b1, `ICS_OFS_IRQ_EN, 32'h0);
    set_lock(1'b0);
    run_op(OP_WORD_RD, 2'b01, 8'h87, 16'h0000);
    apb_xfer(1'b0, `ICS_OFS_RDATA, 32'h0);
    check_val(64'(rdat[15:0]), 64'hFF89);
    apb_xfer(1'b0, `ICS_OFS_IRQ_ST, 32'h0);
    check_val({62'h0, irq, rdat[0]}, 64'h1);
  endtask : t_word_read

  task automatic t_wrong_addr;
    apb_xfer(1'b1, `ICS_OFS_IRQ_CLR, 32'h3);
    apb_xfer(1'b1, `ICS_OFS_IRQ_EN, 32'h2);
    run_op(OP_BYTE_WR, 2'b10, 8'h81, 16'h00C3);
    check_val(64'(rdat[1:0]), 64'h2);
    @(negedge sys_clk);
    check_val(64'(cfg[15:8]), 64'h5A);
    apb_xfer(1'b0, `ICS_OFS_IRQ_ST, 32'h0);
    check_val({62'h0, irq, rdat[1]}, 64'h3);
  endtask : t_wrong_addr

  task automatic tally_and_finish;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  // clock, watchdog, main sequence
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (99000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {rst_b, ce, psel, penable, pwrite, sel_hi, sel_lo, pll_lock} = 8'h44;
    {paddr, pwdata, fail_count, n_tests} = '0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_word_write();
    t_byte_read();
    t_word_read();
    t_wrong_addr();
    tally_and_finish();
  end
endmodule : test_i2c_config_slave

`default_nettype wire
